// >>> logic/tmr0_consts.svh
// constants of the prescaled 8-bit timer/counter: map, fields, codes
`ifndef TMR0_CONSTS_SVH
`define TMR0_CONSTS_SVH

// ------------------------------------------------------------------
// widths
// ------------------------------------------------------------------
`define TMR0_AW 12
`define TMR0_DW 32
`define TMR0_CW 8
`define TMR0_CSW 3
`define TMR0_PSW 10

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define TMR0_OFS_CTRL 12'h000
`define TMR0_OFS_COUNT 12'h004
`define TMR0_OFS_FLAGS 12'h008
`define TMR0_OFS_MASK 12'h00C
`define TMR0_OFS_CLEAR 12'h010

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define TMR0_RST_CS 3'h0
`define TMR0_RST_COUNT 8'h00
`define TMR0_RST_EVT 1'h0
`define TMR0_RST_PS 10'h000
`define TMR0_RST_DATA 32'h00000000

// ------------------------------------------------------------------
// field positions and values
// ------------------------------------------------------------------
`define TMR0_OVF_BIT 0
`define TMR0_COUNT_MAX 8'hFF
`define TMR0_COUNT_ONE 8'h01
`define TMR0_CTRL_PAD 29'h00000000
`define TMR0_COUNT_PAD 24'h000000
`define TMR0_EVT_PAD 31'h00000000

// ------------------------------------------------------------------
// prescaler taps: a tick fires when the low bits of the divider are
// all ones, i.e. once every 8, 64, 256 and 1024 clocks
// ------------------------------------------------------------------
`define TMR0_TAP8_MSB 2
`define TMR0_TAP64_MSB 5
`define TMR0_TAP256_MSB 7
`define TMR0_TAP1024_MSB 9

`endif

// >>> logic/tmr0_pkg.sv
// types shared by the prescaled 8-bit timer/counter
`include "tmr0_consts.svh"

package tmr0_pkg;

   // clock-select codes of the control register
   typedef enum logic [`TMR0_CSW-1:0] {
      TMR0_CS_STOP = 3'h0,
      TMR0_CS_CLK = 3'h1,
      TMR0_CS_DIV8 = 3'h2,
      TMR0_CS_DIV64 = 3'h3,
      TMR0_CS_DIV256 = 3'h4,
      TMR0_CS_DIV1024 = 3'h5,
      TMR0_CS_PINFALL = 3'h6,
      TMR0_CS_PINRISE = 3'h7
   } tmr0_clksel_e;

   // one apb request as seen in its setup cycle
   typedef struct packed {
      logic [`TMR0_AW-1:0] addr;
      logic write;
      logic [`TMR0_DW-1:0] wdata;
   } tmr0_apb_req_s;

   // prescaled tick pulses
   typedef struct packed {
      logic div1024;
      logic div256;
      logic div64;
      logic div8;
   } tmr0_ticks_s;

endpackage : tmr0_pkg

// >>> logic/tmr0_prescaler.sv
// free-running 10-bit prescale divider giving four tick pulses
`timescale 1ns/1ps
`default_nettype none
`include "tmr0_consts.svh"

module tmr0_prescaler
   import tmr0_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   output tmr0_ticks_s ticks
);

   logic [`TMR0_PSW-1:0] div_q;

   // never cleared by software, so the phase of a prescaled tick is
   // unrelated to the moment the counter is started
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= `TMR0_RST_PS;
      end else begin
         div_q <= div_q + 10'h001;
      end
   end

   assign ticks.div8 = &div_q[`TMR0_TAP8_MSB:0];
   assign ticks.div64 = &div_q[`TMR0_TAP64_MSB:0];
   assign ticks.div256 = &div_q[`TMR0_TAP256_MSB:0];
   assign ticks.div1024 = &div_q[`TMR0_TAP1024_MSB:0];

endmodule : tmr0_prescaler

`default_nettype wire

// >>> logic/tmr0_pin_sync.sv
// two-flop synchroniser for the count pin with edge detection
`timescale 1ns/1ps
`default_nettype none

module tmr0_pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic rise,
   output logic fall
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // sampled on every rising clock edge; meta_q feeds sync_q only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'h0;
         sync_q <= 1'h0;
         last_q <= 1'h0;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise = sync_q & ~last_q;
   assign fall = ~sync_q & last_q;

endmodule : tmr0_pin_sync

`default_nettype wire

// >>> logic/tmr0_prescaled_counter.sv
// apb-mapped 8-bit up-counter with prescaled or pin count source
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tmr0_consts.svh"

module tmr0_prescaled_counter
   import tmr0_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TMR0_AW-1:0] paddr,
   input wire logic [`TMR0_DW-1:0] pwdata,
   output logic [`TMR0_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic count_input_pin,
   output logic timer_irq
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   tmr0_clksel_e cs_q;
   tmr0_clksel_e cs_d;
   logic [`TMR0_CW-1:0] count_q;
   logic [`TMR0_CW-1:0] count_d;
   logic ovf_flag_q;
   logic ovf_flag_d;
   logic ovf_mask_q;
   logic ovf_mask_d;
   logic [`TMR0_DW-1:0] prdata_q;
   logic [`TMR0_DW-1:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   logic irq_q;
   logic irq_d;

   // ------------------------------------------------------------------
   // apb request decode
   // ------------------------------------------------------------------
   tmr0_apb_req_s req;
   wire setup_cyc;
   wire access_done;
   wire wr_done;
   wire hit_ctrl;
   wire hit_count;
   wire hit_flags;
   wire hit_mask;
   wire hit_clear;
   wire hit_any;
   wire rd_only_hit;
   wire wr_only_hit;
   wire bad_access;

   assign req.addr = paddr;
   assign req.write = pwrite;
   assign req.wdata = pwdata;

   // pready is registered: it rises in the first access cycle, so
   // every transfer completes with no wait state
   assign setup_cyc = psel & ~penable;
   assign access_done = psel & penable & pready_q;
   assign wr_done = access_done & req.write & ~pslverr_q;

   assign hit_ctrl = (req.addr == `TMR0_OFS_CTRL);
   assign hit_count = (req.addr == `TMR0_OFS_COUNT);
   assign hit_flags = (req.addr == `TMR0_OFS_FLAGS);
   assign hit_mask = (req.addr == `TMR0_OFS_MASK);
   assign hit_clear = (req.addr == `TMR0_OFS_CLEAR);
   assign hit_any = hit_ctrl | hit_count | hit_flags | hit_mask | hit_clear;

   // the flag register only reads, the clear register only writes
   assign rd_only_hit = hit_flags;
   assign wr_only_hit = hit_clear;
   assign bad_access = ~hit_any
                     | (req.write & rd_only_hit)
                     | (~req.write & wr_only_hit);

   // ------------------------------------------------------------------
   // write strobes
   // ------------------------------------------------------------------
   wire wr_ctrl;
   wire wr_count;
   wire wr_mask;
   wire wr_clear;

   assign wr_ctrl = wr_done & hit_ctrl;
   assign wr_count = wr_done & hit_count;
   assign wr_mask = wr_done & hit_mask;
   assign wr_clear = wr_done & hit_clear;

   // ------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------
   wire [`TMR0_DW-1:0] rd_ctrl;
   wire [`TMR0_DW-1:0] rd_count;
   wire [`TMR0_DW-1:0] rd_flags;
   wire [`TMR0_DW-1:0] rd_mask;
   wire [`TMR0_DW-1:0] rd_mux;

   assign rd_ctrl = {`TMR0_CTRL_PAD, cs_q};
   assign rd_count = {`TMR0_COUNT_PAD, count_q};
   assign rd_flags = {`TMR0_EVT_PAD, ovf_flag_q};
   assign rd_mask = {`TMR0_EVT_PAD, ovf_mask_q};

   assign rd_mux = hit_ctrl ? rd_ctrl :
                   hit_count ? rd_count :
                   hit_flags ? rd_flags :
                   hit_mask ? rd_mask :
                   `TMR0_RST_DATA;

   // ------------------------------------------------------------------
   // count sources
   // ------------------------------------------------------------------
   tmr0_ticks_s ticks;
   logic pin_rise;
   logic pin_fall;

   tmr0_prescaler u_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .ticks(ticks)
   );

   // the port carries the pad level, which is synchronised here
   // before its rising and falling edges are detected for counting
   tmr0_pin_sync u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(count_input_pin),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // ------------------------------------------------------------------
   // clock-select decode
   // ------------------------------------------------------------------
   wire sel_stop;
   wire sel_clk;
   wire sel_div8;
   wire sel_div64;
   wire sel_div256;
   wire sel_div1024;
   wire sel_fall;
   wire sel_rise;
   wire count_tick;

   assign sel_stop = (cs_q == TMR0_CS_STOP);
   assign sel_clk = (cs_q == TMR0_CS_CLK);
   assign sel_div8 = (cs_q == TMR0_CS_DIV8);
   assign sel_div64 = (cs_q == TMR0_CS_DIV64);
   assign sel_div256 = (cs_q == TMR0_CS_DIV256);
   assign sel_div1024 = (cs_q == TMR0_CS_DIV1024);
   assign sel_fall = (cs_q == TMR0_CS_PINFALL);
   assign sel_rise = (cs_q == TMR0_CS_PINRISE);

   // stop yields no tick, so the counter simply holds
   assign count_tick = ~sel_stop & (
                         sel_clk
                       | (sel_div8 & ticks.div8)
                       | (sel_div64 & ticks.div64)
                       | (sel_div256 & ticks.div256)
                       | (sel_div1024 & ticks.div1024)
                       | (sel_fall & pin_fall)
                       | (sel_rise & pin_rise));

   // ------------------------------------------------------------------
   // counter and overflow
   // ------------------------------------------------------------------
   wire at_max;
   wire overflow;

   assign at_max = (count_q == `TMR0_COUNT_MAX);
   // a write in the same cycle as a tick wins, so an overflow that the
   // write replaces is not reported
   assign overflow = count_tick & at_max & ~wr_count;

   always_comb begin
      count_d = count_q;
      if (wr_count) begin
         count_d = req.wdata[`TMR0_CW-1:0];
      end else if (count_tick) begin
         count_d = count_q + `TMR0_COUNT_ONE;
      end
   end

   always_comb begin
      cs_d = cs_q;
      if (wr_ctrl) begin
         cs_d = tmr0_clksel_e'(req.wdata[`TMR0_CSW-1:0]);
      end
   end

   // ------------------------------------------------------------------
   // interrupt flag, mask and output
   // ------------------------------------------------------------------
   wire clr_ovf;

   assign clr_ovf = wr_clear & req.wdata[`TMR0_OVF_BIT];

   always_comb begin
      ovf_flag_d = ovf_flag_q;
      // a set in the clearing cycle wins over the clear
      if (overflow) begin
         ovf_flag_d = 1'h1;
      end else if (clr_ovf) begin
         ovf_flag_d = 1'h0;
      end
   end

   always_comb begin
      ovf_mask_d = ovf_mask_q;
      if (wr_mask) begin
         ovf_mask_d = req.wdata[`TMR0_OVF_BIT];
      end
   end

   assign irq_d = ovf_flag_q & ovf_mask_q;

   // ------------------------------------------------------------------
   // bus answer
   // ------------------------------------------------------------------
   always_comb begin
      pready_d = 1'h0;
      pslverr_d = 1'h0;
      prdata_d = prdata_q;
      if (setup_cyc) begin
         pready_d = 1'h1;
         pslverr_d = bad_access;
         prdata_d = req.write ? `TMR0_RST_DATA : rd_mux;
      end
   end

   // ------------------------------------------------------------------
   // registers: clock select and count
   // ------------------------------------------------------------------
   // reset picks stop, so nothing counts until software sets a source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_q <= TMR0_CS_STOP;
      end else begin
         cs_q <= cs_d;
      end
   end

   // one next-value path: a bus write simply replaces the increment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= `TMR0_RST_COUNT;
      end else begin
         count_q <= count_d;
      end
   end

   // ------------------------------------------------------------------
   // registers: overflow flag, mask and interrupt
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_flag_q <= `TMR0_RST_EVT;
      end else begin
         ovf_flag_q <= ovf_flag_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_mask_q <= `TMR0_RST_EVT;
      end else begin
         ovf_mask_q <= ovf_mask_d;
      end
   end

   // the pin comes straight from a flop, so it trails flag and mask
   // by one cycle; software sees no glitch from the and gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= `TMR0_RST_EVT;
      end else begin
         irq_q <= irq_d;
      end
   end

   // ------------------------------------------------------------------
   // registers: bus answer
   // ------------------------------------------------------------------
   // read data holds between transfers; only pready marks it valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= `TMR0_RST_DATA;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // pready resets low, so a transfer cut by reset is never answered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= `TMR0_RST_EVT;
      end else begin
         pready_q <= pready_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_q <= `TMR0_RST_EVT;
      end else begin
         pslverr_q <= pslverr_d;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // every output is a flop's q, so no decode hazard reaches a port
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign timer_irq = irq_q;

endmodule : tmr0_prescaled_counter

`default_nettype wire

// >>> sim/tmr0_monitor.sv
// port checker of the prescaled timer
`timescale 1ns/1ps
`default_nettype none
`include "tmr0_consts.svh"

module tmr0_mon
   import tmr0_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TMR0_AW-1:0] paddr,
   input wire logic [`TMR0_DW-1:0] pwdata,
   input wire logic [`TMR0_DW-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic count_input_pin,
   input wire logic timer_irq
);
   wire logic setup = psel && !penable;
   wire logic rd = pready && !pwrite;
   wire logic ok = paddr inside {`TMR0_OFS_CTRL, `TMR0_OFS_COUNT,
      `TMR0_OFS_FLAGS, `TMR0_OFS_MASK, `TMR0_OFS_CLEAR};
   // flags are read-only, the clear strobe write-only
   wire logic bad_dir = pwrite ? paddr == `TMR0_OFS_FLAGS
      : paddr == `TMR0_OFS_CLEAR;
   wire logic mask_off = psel && penable && pwrite && !pwdata[0]
      && paddr == `TMR0_OFS_MASK;

   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   zero_wait_a: assert property (setup |=> pready)
      else $error("no zero-wait answer");
   ready_once_a: assert property (pready |=> !pready)
      else $error("pready held");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   unmapped_err_a: assert property (setup && !ok |=> pslverr)
      else $error("unmapped access accepted");
   wrong_dir_err_a: assert property (setup && bad_dir |=> pslverr)
      else $error("refused access accepted");
   legal_ok_a: assert property (setup && ok && !bad_dir |=> !pslverr)
      else $error("legal access refused");
   wr_rdata_zero_a: assert property (pready && pwrite |-> prdata == 0)
      else $error("read data on a write");
   ctrl_pad_zero_a: assert property
      (rd && paddr == `TMR0_OFS_CTRL |-> prdata[31:3] == 0)
      else $error("control pad bits set");
   count_pad_zero_a: assert property
      (rd && paddr == `TMR0_OFS_COUNT |-> prdata[31:8] == 0)
      else $error("count wider than 8 bits");
   irq_masked_a: assert property (mask_off |=> ##1 !timer_irq)
      else $error("irq with mask clear");

   cover property (pready && pslverr);
   cover property ($rose(timer_irq));
   cover property (rd && paddr == `TMR0_OFS_COUNT && prdata != 0);
endmodule : tmr0_mon

bind tmr0_prescaled_counter tmr0_mon tmr0_mon_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .count_input_pin(count_input_pin),
   .timer_irq(timer_irq));
`default_nettype wire

// >>> sim/tmr0_pin_source.sv
// count-pin source: a run of level changes with a chosen spacing
`timescale 1ns/1ps
`default_nettype none

module tmr0_pin_source (
   input wire logic pclk,
   input wire logic start,
   input wire logic [7:0] n_toggles,
   input wire logic [3:0] gap,
   output logic pin,
   output logic busy
);
   logic [7:0] left_q;
   logic [3:0] wait_q;
   initial begin
      pin = 1'b0;
      left_q = 8'h00;
      wait_q = 4'h0;
   end
   assign busy = left_q != 8'h00;
   // gap 0 still leaves one full clock between changes
   always @(posedge pclk) begin
      if (start && !busy) begin
         left_q <= n_toggles;
         wait_q <= gap;
      end else if (busy && wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end else if (busy) begin
         pin <= !pin;
         left_q <= left_q - 8'h01;
         wait_q <= gap;
      end
   end
endmodule : tmr0_pin_source
`default_nettype wire

// >>> sim/tb.sv
// timer bench: apb master, reference model, pin source
`timescale 1ns/1ps
`default_nettype none
`include "tmr0_consts.svh"

module tb;
   import tmr0_pkg::*;
   localparam logic [11:0] ct = `TMR0_OFS_CTRL;
   localparam logic [11:0] cn = `TMR0_OFS_COUNT;
   localparam logic [11:0] fl = `TMR0_OFS_FLAGS;
   localparam logic [11:0] mk = `TMR0_OFS_MASK;
   localparam logic [11:0] cl = `TMR0_OFS_CLEAR;
   localparam logic [3:0][11:0] map_adr = {mk, fl, cn, ct};
   localparam logic [2:0][11:0] bad_adr = {12'hFFC, 12'h002, 12'h014};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic irq, pin, go, busy, s1, s2, s3, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [7:0] n_tog;
   logic [3:0] gap;
   integer n_errors = 0, cmp_count = 0, seed = 32'hc9427e0c;
   integer ps, cnt, cs, flag, mask, irq_m, exp_rd, k;
   wire logic wr_acc = psel && penable && pwrite;

   tmr0_prescaled_counter tmr0_prescaled_counter_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_input_pin(pin), .timer_irq(irq));
   tmr0_pin_source tmr0_pin_source_i (.pclk(pclk), .start(go),
      .n_toggles(n_tog), .gap(gap), .pin(pin), .busy(busy));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   function automatic logic tick(input integer c);
      case (c)
         1: return 1'b1;
         2: return ps % 8 == 7;
         3: return ps % 64 == 63;
         4: return ps % 256 == 255;
         5: return ps % 1024 == 1023;
         6: return !s2 && s3;
         7: return s2 && !s3;
         default: return 1'b0;
      endcase
   endfunction : tick

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {s1, s2, s3} <= 3'h0;
         {ps, cnt, cs, flag, mask, irq_m} <= '0;
      end else begin
         ps <= ps + 1;
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         irq_m <= flag & mask;
         if (psel && !penable)
            exp_rd <= paddr == ct ? cs : paddr == cn ? cnt :
               paddr == fl ? flag : paddr == mk ? mask : 0;
         if (wr_acc && paddr == ct) cs <= pwdata[2:0];
         if (wr_acc && paddr == mk) mask <= pwdata[0];
         if (wr_acc && paddr == cl && pwdata[0]) flag <= 0;
         if (wr_acc && paddr == cn) cnt <= pwdata[7:0];
         else if (tick(cs)) begin
            cnt <= (cnt + 1) % 256;
            if (cnt == 255) flag <= 1;
         end
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_errors++;
         $display("FAIL t=%0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      integer n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      check({31'h0, n < 40}, 32'h1);
      rdv = prdata;
      err = pslverr;
   endtask : apb

   task automatic idle;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : idle

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic e);
      apb(1'b1, a, d);
      check({31'h0, err}, {31'h0, e});
   endtask : wr

   task automatic rd_chk(input logic [11:0] a);
      apb(1'b0, a, $random(seed));
      check(rdv, exp_rd);
      check({31'h0, irq}, irq_m);
      check({31'h0, err}, 32'h0);
   endtask : rd_chk

   task automatic pin_run(input integer c);
      integer n;
      n = 0;
      wr(cn, $random(seed), 1'b0);
      wr(ct, c, 1'b0);
      idle;
      go <= 1'b1;
      n_tog <= 8'(4 + ($random(seed) & 15));
      gap <= 4'($random(seed) & 3);
      @(posedge pclk);
      go <= 1'b0;
      do begin
         @(posedge pclk);
         n++;
      end while (busy && n < 2000);
      repeat (4) @(posedge pclk);
      rd_chk(cn);
      idle;
   endtask : pin_run

   task automatic summarize;
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   initial begin
      #400000;
      n_errors++;
      $display("FAIL t=%0t watchdog expired", $time);
      summarize;
   end

   initial begin
      {presetn, psel, penable, pwrite, go} = 5'h0;
      {paddr, pwdata, n_tog, gap} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (k = 0; k < 4; k++) rd_chk(map_adr[k]);
      wr(ct, 32'hFFFFFFF8, 1'b0);
      rd_chk(ct);
      idle;
      $display("test reset and padding done");
      for (k = 1; k < 6; k++) begin
         wr(cn, $random(seed), 1'b0);
         wr(ct, k, 1'b0);
         idle;
         repeat (300 * k) @(posedge pclk);
         rd_chk(cn);
         rd_chk(fl);
         wr(ct, 0, 1'b0);
         idle;
         repeat (5) @(posedge pclk);
         rd_chk(cn);
         idle;
      end
      $display("test prescaled sources done");
      wr(mk, 1, 1'b0);
      wr(cn, 32'hFE, 1'b0);
      wr(ct, 1, 1'b0);
      idle;
      repeat (3) @(posedge pclk);
      rd_chk(fl);
      wr(cl, 1, 1'b0);
      rd_chk(fl);
      wr(fl, 1, 1'b1);
      apb(1'b0, cl, 0);
      check({31'h0, err}, 32'h1);
      for (k = 0; k < 3; k++) begin
         apb(k[0], bad_adr[k], $random(seed));
         check({31'h0, err}, 32'h1);
      end
      wr(cn, $random(seed), 1'b0);
      rd_chk(cn);
      wr(mk, 0, 1'b0);
      idle;
      repeat (300) @(posedge pclk);
      rd_chk(fl);
      idle;
      $display("test overflow and irq done");
      for (k = 0; k < 4; k++) pin_run(6 + k % 2);
      $display("test count pin done");
      wr(ct, 1, 1'b0);
      idle;
      repeat (20) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (k = 0; k < 4; k++) rd_chk(map_adr[k]);
      idle;
      $display("test reset in mid-run done");
      summarize;
   end
endmodule : tb
`default_nettype wire
